// *** rtl/inbound_fifo.v ***
/*
 * small inbound transaction queue, register array with counters.
 * assumes one clock, synchronous active-low reset, and a caller that
 * never pushes while full or pops while empty.
 */
`timescale 1ns/100ps
`default_nettype none
`include "inbound_queue_regs.vh"
module inbound_fifo #(
    parameter WIDTH = `ENT_W,
    parameter DEPTH = `IQ_DEPTH,
    parameter CW    = `IQ_CNT_W
) (
    input  wire             ref_clk_i,
    input  wire             reset_n_i,
    input  wire             push_i,
    input  wire [WIDTH-1:0] push_data_i,
    input  wire             pop_i,
    output wire [WIDTH-1:0] head_o,
    output wire             full_o,
    output wire             empty_o
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [CW-1:0]    wptr_r;
    reg [CW-1:0]    rptr_r;
    reg [CW:0]      cnt_r;
    // ----------------------------------------------------------------
    // storage and pointers
    // ----------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            wptr_r <= {CW{1'b0}};
            rptr_r <= {CW{1'b0}};
            cnt_r  <= {(CW+1){1'b0}};
        end else begin
            if (push_i) begin
                mem_r[wptr_r] <= push_data_i;
                wptr_r <= (wptr_r == DEPTH-1) ? {CW{1'b0}} : wptr_r + 1'b1;
            end
            if (pop_i)
                rptr_r <= (rptr_r == DEPTH-1) ? {CW{1'b0}} : rptr_r + 1'b1;
            if (push_i && !pop_i)
                cnt_r <= cnt_r + 1'b1;
            else if (pop_i && !push_i)
                cnt_r <= cnt_r - 1'b1;
        end
    end
    assign head_o  = mem_r[rptr_r];
    assign full_o  = (cnt_r == DEPTH);
    assign empty_o = (cnt_r == {(CW+1){1'b0}});
endmodule // inbound_fifo
`default_nettype wire

// *** rtl/inbound_queue_regs.vh ***
/*
 * constants for the inbound queue / dma target block.
 * assumes inclusion by bare name from rtl/ modules.
 */
// Contract
// - inbound queue holds at most three standard transfers, then is full.
// - dma moves data as 8-word read or write bursts to one target.
// - no inbound entry leaves the queue while a dma burst is pending; here only the start is held off, an entry already running still pops.
// - a new inbound transfer arriving at a full queue is retried.
// - between dma bursts at least one inbound entry is removed.
// - inbound memory reads are served by prefetching past requested words.
// - prefetch running into a reserved region gets an ahb error.
// - the read whose prefetch erred still completes normally on pci.
`ifndef INBOUND_QUEUE_REGS_VH
`define INBOUND_QUEUE_REGS_VH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define IQ_DEPTH        3
`define IQ_CNT_W        2
`define DMA_BURST_WORDS 8
`define DMA_CNT_W       4
`define PF_EXTRA_WORDS  4
`define PF_CNT_W        4
// ----------------------------------------------------------------
// entry layout: {cmd_write, doorbell, len[3:0], addr[31:0]}
// ----------------------------------------------------------------
`define ENT_W           38
`define ENT_ADDR_LSB    0
`define ENT_LEN_LSB     32
`define ENT_DB_BIT      36
`define ENT_WR_BIT      37
`endif

// *** rtl/pci_inbound_queue_dma_target.v ***
/*
 * pci target queue and dma master sequencing for the pci controller.
 * assumes a pci front end that presents decoded transfers as a one-cycle
 * request, an ahb master port with single-cycle handshake, and a dma
 * front end that reports burst words as they move on pci.
 */
`timescale 1ns/100ps
`default_nettype none
`include "inbound_queue_regs.vh"
module pci_inbound_queue_dma_target #(
    parameter BURST = `DMA_BURST_WORDS,
    parameter PF_N  = `PF_EXTRA_WORDS
) (
    input  wire        ref_clk_i,
    input  wire        reset_n_i,
    // inbound transfer from an external pci master
    input  wire        in_req_i,
    input  wire        in_write_i,
    input  wire        in_doorbell_i,
    input  wire [3:0]  in_len_i,
    input  wire [31:0] in_addr_i,
    output reg         in_accept_o,
    output reg         in_retry_o,
    // dma burst control
    input  wire        dma_start_i,
    input  wire        dma_write_i,
    input  wire [31:0] dma_addr_i,
    input  wire        dma_word_i,
    output reg         dma_busy_o,
    output reg         dma_write_o,
    output reg  [31:0] dma_addr_o,
    output reg         dma_done_o,
    // ahb master side for inbound execution
    output reg         ahb_req_o,
    output reg         ahb_write_o,
    output reg  [31:0] ahb_addr_o,
    input  wire        ahb_ack_i,
    input  wire        ahb_err_i,
    // completion back to pci
    output reg         rd_done_o,
    output reg  [3:0]  rd_words_o,
    output reg         pf_err_o,
    output reg         doorbell_irq_o
);
    // execution states, one-hot: idle waits for work, req runs the
    // demanded words, pf reads ahead, done pops and reports
    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_REQ  = 4'h2;
    localparam [3:0] S_PF   = 4'h4;
    localparam [3:0] S_DONE = 4'h8;

    // ----------------------------------------------------------------
    // internal state
    // ----------------------------------------------------------------
    wire [`ENT_W-1:0] head;
    wire              q_full;
    wire              q_empty;
    wire              push;
    wire              pop;
    reg  [3:0]        st_r;
    reg  [`DMA_CNT_W-1:0] dma_cnt_r;
    reg               gap_r;       // a burst ended, one pop owed
    reg  [3:0]        word_r;
    reg  [`PF_CNT_W-1:0] pf_r;
    reg  [3:0]        len_r;
    reg               pf_seen_r;

    // ----------------------------------------------------------------
    // accept or retry inbound transfers
    // ----------------------------------------------------------------
    // a pop in the same cycle does not free a slot early; keeps the
    // full decision purely registered
    assign push = in_req_i && !q_full;
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            in_accept_o <= 1'b0;
            in_retry_o  <= 1'b0;
        end else begin
            in_accept_o <= push;
            in_retry_o  <= in_req_i && q_full;
        end
    end

    inbound_fifo u_fifo (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .push_i      (push),
        .push_data_i ({in_write_i, in_doorbell_i, in_len_i, in_addr_i}),
        .pop_i       (pop),
        .head_o      (head),
        .full_o      (q_full),
        .empty_o     (q_empty)
    );

    // ----------------------------------------------------------------
    // dma burst sequencing
    // ----------------------------------------------------------------
    // a new burst may not start while an owed pop is outstanding and
    // the queue holds work; this breaks the ordering deadlock
    wire dma_go = dma_start_i && !dma_busy_o && !(gap_r && !q_empty);
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            dma_busy_o  <= 1'b0;
            dma_write_o <= 1'b0;
            dma_addr_o  <= 32'h0000_0000;
            dma_cnt_r   <= {`DMA_CNT_W{1'b0}};
            dma_done_o  <= 1'b0;
            gap_r       <= 1'b0;
        end else begin
            dma_done_o <= 1'b0;
            // the owed pop is cleared first so that a burst ending in the
            // same cycle as a pop still leaves a pop owed
            if (pop || (q_empty && !dma_busy_o))
                gap_r <= 1'b0;
            if (dma_go) begin
                dma_busy_o  <= 1'b1;
                dma_write_o <= dma_write_i;
                dma_addr_o  <= dma_addr_i; // single target per burst
                dma_cnt_r   <= {`DMA_CNT_W{1'b0}};
            end else if (dma_busy_o && dma_word_i) begin
                if (dma_cnt_r == BURST-1) begin
                    dma_busy_o <= 1'b0;
                    dma_done_o <= 1'b1;
                    gap_r      <= 1'b1;
                end
                dma_cnt_r <= dma_cnt_r + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // inbound execution engine
    // ----------------------------------------------------------------
    // entries start executing only when no burst is pending on pci; one already running still pops during a burst
    wire can_issue = !q_empty && !dma_busy_o;
    // a slot is freed only once its entry has fully executed
    assign pop = (st_r == S_DONE);
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            st_r           <= S_IDLE;
            ahb_req_o      <= 1'b0;
            ahb_write_o    <= 1'b0;
            ahb_addr_o     <= 32'h0000_0000;
            word_r         <= 4'h0;
            pf_r           <= {`PF_CNT_W{1'b0}};
            len_r          <= 4'h0;
            pf_seen_r      <= 1'b0;
            rd_done_o      <= 1'b0;
            rd_words_o     <= 4'h0;
            pf_err_o       <= 1'b0;
            doorbell_irq_o <= 1'b0;
        end else begin
            rd_done_o      <= 1'b0;
            doorbell_irq_o <= 1'b0;
            case (st_r)
            S_IDLE: begin
                // hold off only for a burst starting on this very edge; a
                // start request that is refused must not block the owed pop
                if (can_issue && !dma_go) begin
                    ahb_req_o   <= 1'b1;
                    ahb_write_o <= head[`ENT_WR_BIT];
                    ahb_addr_o  <= head[`ENT_ADDR_LSB +: 32];
                    len_r       <= head[`ENT_LEN_LSB +: 4];
                    word_r      <= 4'h0;
                    pf_r        <= {`PF_CNT_W{1'b0}};
                    pf_seen_r   <= 1'b0;
                    st_r        <= S_REQ;
                end
            end
            S_REQ: begin
                // demanded words: an error here is ignored, the master
                // still gets its data
                if (ahb_ack_i || ahb_err_i) begin
                    ahb_addr_o <= ahb_addr_o + 32'h0000_0004;
                    word_r     <= word_r + 4'h1;
                    if (word_r == len_r) begin
                        if (ahb_write_o) begin
                            ahb_req_o <= 1'b0;
                            st_r      <= S_DONE;
                        end else begin
                            st_r <= S_PF; // read ahead
                        end
                    end
                end
            end
            S_PF: begin
                // read-ahead stops at the first error; nothing past the hole
                if (ahb_err_i) begin
                    pf_seen_r <= 1'b1; // reserved hole
                    ahb_req_o <= 1'b0;
                    st_r      <= S_DONE;
                end else if (ahb_ack_i) begin
                    ahb_addr_o <= ahb_addr_o + 32'h0000_0004;
                    pf_r       <= pf_r + 1'b1;
                    if (pf_r == PF_N-1) begin
                        ahb_req_o <= 1'b0;
                        st_r      <= S_DONE;
                    end
                end
            end
            S_DONE: begin
                // a prefetch error reaches pci only as pf_err_o; the demanded words
                // complete normally
                rd_done_o      <= !ahb_write_o;
                rd_words_o     <= len_r + 4'h1;
                pf_err_o       <= pf_seen_r;
                // clearing here keeps a stale error from touching the next
                // transfer
                pf_seen_r      <= 1'b0;
                doorbell_irq_o <= head[`ENT_DB_BIT] && head[`ENT_WR_BIT];
                st_r           <= S_IDLE;
            end
            default: begin
                // an illegal state falls back to idle with the bus released
                st_r      <= S_IDLE;
                ahb_req_o <= 1'b0;
            end
            endcase
        end
    end
endmodule // pci_inbound_queue_dma_target
`default_nettype wire

// *** testbench/ahb_mem_model.sv ***
/* far-side ahb memory: acks below a hole, errors at and above it.
   assumes req and addr hold until each answer. */
`timescale 1ns/100ps
`default_nettype none
module ahb_mem_model #(parameter logic [31:0] HOLE = 32'h0000_1000) (
    input  wire logic        ref_clk_i,
    input  wire logic        req_i,
    input  wire logic [31:0] addr_i,
    input  wire logic        slow_i,
    output var  logic        ack_o,
    output var  logic        err_o
);
    logic wait_r;
    // one answer per beat; slow mode adds a wait cycle before each
    always @(posedge ref_clk_i) begin
        if (!req_i || ack_o || err_o) begin
            ack_o  <= 1'b0;
            err_o  <= 1'b0;
            wait_r <= slow_i;
        end else if (wait_r) begin
            wait_r <= 1'b0;
        end else begin
            ack_o <= addr_i < HOLE;
            err_o <= addr_i >= HOLE;
        end
    end
endmodule // ahb_mem_model
`default_nettype wire

// *** testbench/iq_dma_sva.sv ***
/* checker for queue depth, dma bursts and prefetch beats.
   bound to the block top; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module iq_dma_sva #(parameter PF_N = 4) (
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic        in_req_i,
    input wire logic        in_accept_o,
    input wire logic        in_retry_o,
    input wire logic [31:0] dma_addr_i,
    input wire logic        dma_word_i,
    input wire logic        dma_busy_o,
    input wire logic [31:0] dma_addr_o,
    input wire logic        dma_done_o,
    input wire logic        ahb_req_o,
    input wire logic        ahb_ack_i,
    input wire logic        ahb_err_i,
    input wire logic        rd_done_o,
    input wire logic [3:0]  rd_words_o,
    input wire logic        pf_err_o
);
    // ----
    // helpers
    // ----
    // pend is queued-but-not-started entries: a floor on queue depth
    logic [2:0] cnt_r;
    logic [3:0] wcnt_r;
    logic [4:0] beat_r;
    logic       req_q;
    wire        rise = ahb_req_o & ~req_q;
    wire        beat = ahb_req_o & (ahb_ack_i | ahb_err_i);
    wire  [2:0] pend = cnt_r + {2'h0, in_accept_o};
    always @(posedge ref_clk_i) begin
        req_q  <= ahb_req_o;
        cnt_r  <= !reset_n_i ? 3'h0 : pend - {2'h0, rise};
        wcnt_r <= !dma_busy_o ? 4'h0 : wcnt_r + {3'h0, dma_word_i};
        beat_r <= rise ? 5'h0 : beat_r + {4'h0, beat};
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_last_word;
        dma_busy_o && wcnt_r == 4'h7 && dma_word_i;
    endsequence
    a_req_answer: assert property (in_req_i |=> in_accept_o ^ in_retry_o)
        else $error("request not answered once");
    a_full_retry: assert property (in_req_i && pend >= 3'h3 |=> in_retry_o)
        else $error("full queue did not retry");
    a_room_accept: assert property (in_req_i && pend == 3'h0 |=>
        in_accept_o) else $error("request refused with room");
    a_no_exec: assert property ($rose(ahb_req_o) |-> !dma_busy_o)
        else $error("entry started during burst");
    a_last_word: assert property (s_last_word |=> dma_done_o && !dma_busy_o)
        else $error("burst did not end after eight words");
    a_burst_target: assert property ($rose(dma_busy_o) |->
        dma_addr_o == $past(dma_addr_i)) else $error("burst target lost");
    a_prefetch_run: assert property (rd_done_o && !pf_err_o |->
        beat_r == rd_words_o + PF_N) else $error("prefetch beats wrong");
    a_err_read: assert property (rd_done_o && pf_err_o |->
        beat_r > rd_words_o && beat_r <= rd_words_o + PF_N)
        else $error("erred read cut short");
endmodule // iq_dma_sva
`default_nettype wire

// *** testbench/test_pci_inbound_queue_dma_target.sv ***
/* bench: scenarios checked against a queue of expected completions.
   assumes the checker and the memory model compile first. */
`timescale 1ns/100ps
`default_nettype none
module test_pci_inbound_queue_dma_target;
    localparam int          PF   = 4;
    localparam int          BST  = 8;
    localparam logic [31:0] HOLE = 32'h0000_1000;
    logic ref_clk_i = 1'b0, reset_n_i = 1'b0, slow = 1'b0;
    logic in_req_i = 1'b0, in_write_i = 1'b0, in_doorbell_i = 1'b0;
    logic dma_start_i = 1'b0, dma_write_i = 1'b0, dma_word_i = 1'b0;
    logic [3:0]  in_len_i = 4'h0, rd_words_o, len;
    logic [31:0] in_addr_i = 32'h0, dma_addr_i = 32'h0, a;
    logic [31:0] dma_addr_o, ahb_addr_o;
    logic in_accept_o, in_retry_o, dma_busy_o, dma_write_o, dma_done_o;
    logic ahb_req_o, ahb_write_o, ahb_ack_i, ahb_err_i;
    logic rd_done_o, pf_err_o, doorbell_irq_o;
    int   error_cnt = 0, checks = 0, e, n0;
    int   exp_q[$];
    logic [31:0] adr_q[$];
    logic req_d = 1'b0;
    pci_inbound_queue_dma_target #(.BURST(BST), .PF_N(PF)) DUT (
        .ref_clk_i, .reset_n_i, .in_req_i, .in_write_i, .in_doorbell_i,
        .in_len_i, .in_addr_i, .in_accept_o, .in_retry_o, .dma_start_i,
        .dma_write_i, .dma_addr_i, .dma_word_i, .dma_busy_o, .dma_write_o,
        .dma_addr_o, .dma_done_o, .ahb_req_o, .ahb_write_o, .ahb_addr_o,
        .ahb_ack_i, .ahb_err_i, .rd_done_o, .rd_words_o, .pf_err_o,
        .doorbell_irq_o);
    ahb_mem_model #(.HOLE(HOLE)) far (.ref_clk_i, .req_i(ahb_req_o),
        .addr_i(ahb_addr_o), .slow_i(slow), .ack_o(ahb_ack_i),
        .err_o(ahb_err_i));
    always #5 ref_clk_i = ~ref_clk_i;
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one inbound transfer; a write always rings the doorbell
    task automatic issue(input logic w, input logic [3:0] l,
                         input logic [31:0] ad, input logic acc);
        @(posedge ref_clk_i);
        in_req_i <= 1'b1;
        in_write_i <= w;
        in_doorbell_i <= w;
        in_len_i <= l;
        in_addr_i <= ad;
        @(posedge ref_clk_i);
        in_req_i <= 1'b0;
        #1;
        check("accept", in_accept_o, acc);
        check("retry", in_retry_o, !acc);
        if (acc) begin
            exp_q.push_back(w ? 32'h100 : (l + 1) * 2 + (ad + 4 * (l + PF) >= HOLE));
            adr_q.push_back(ad);
        end
    endtask
    task automatic drain();
        for (int i = 0; i < 400 && exp_q.size() != 0; i++)
            @(posedge ref_clk_i);
        check("drained", exp_q.size(), 32'h0);
    endtask
    // start pulses leave room for a pending entry to run
    task automatic dma_go(input logic [31:0] ad);
        for (int i = 0; i < 200; i++) begin
            @(posedge ref_clk_i);
            dma_start_i <= 1'b1;
            dma_addr_i <= ad;
            dma_write_i <= ad[12];
            @(posedge ref_clk_i);
            dma_start_i <= 1'b0;
            @(posedge ref_clk_i);
            if (dma_busy_o === 1'b1) break;
        end
        check("target", dma_addr_o, ad);
        check("dir", dma_write_o, ad[12]);
    endtask
    task automatic dma_words();
        @(posedge ref_clk_i);
        for (int i = 0; i < BST; i++) begin
            dma_word_i <= 1'b1;
            @(posedge ref_clk_i);
            if (i == BST - 1 || $urandom % 2) begin
                dma_word_i <= 1'b0;
                if (i < BST - 1) @(posedge ref_clk_i);
            end
        end
        #1;
        check("done", dma_done_o, 1'b1);
    endtask
    // each completion is matched to the oldest expected entry
    always @(posedge ref_clk_i) begin
        #1;
        if (rd_done_o === 1'b1 || doorbell_irq_o === 1'b1) begin
            e = exp_q.pop_front();
            check("irq", doorbell_irq_o, e[8]);
            check("rd_done", rd_done_o, !e[8]);
            if (!e[8]) check("words", rd_words_o, e[4:1]);
            if (!e[8]) check("pf_err", pf_err_o, e[0]);
        end
        // an entry starts on the bus with its own address and direction
        if (ahb_req_o === 1'b1 && !req_d) begin
            check("ahb_addr", ahb_addr_o, adr_q.pop_front());
            check("ahb_write", ahb_write_o, exp_q[0][8]);
        end
        req_d = (ahb_req_o === 1'b1);
    end
    initial begin
        void'($urandom(38));
        repeat (8) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        check("idle", {in_accept_o, dma_busy_o, ahb_req_o, pf_err_o}, 0);
        // reads, reads whose prefetch meets the hole, doorbell writes
        for (int i = 0; i < 12; i++) begin
            len = $urandom % 8;
            a = (i % 3 == 2) ? HOLE - 4 * (len + 1 + $urandom % PF)
                             : 32'h100 + 4 * ($urandom % 64);
            slow <= $urandom % 2;
            issue(i % 4 == 3, len, a, 1'b1);
            drain();
        end
        $display("test reads done");
        // four transfers during one burst: the fourth must be retried
        dma_go(32'h2000);
        for (int i = 0; i < 4; i++)
            issue(1'b0, 4'h1, 32'h200 + 32 * i, i < 3);
        dma_words();
        n0 = exp_q.size();
        dma_go(32'h3000);
        check("popped", exp_q.size() < n0, 1'b1);
        dma_words();
        drain();
        $display("test dma done");
        end_of_test();
    end
    // the scenarios need a few hundred cycles; this cuts a hang at 20000 cycles
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
endmodule // test_pci_inbound_queue_dma_target
bind pci_inbound_queue_dma_target iq_dma_sva #(.PF_N(PF_N)) chk (
    .ref_clk_i, .reset_n_i, .in_req_i, .in_accept_o, .in_retry_o,
    .dma_addr_i, .dma_word_i, .dma_busy_o, .dma_addr_o, .dma_done_o,
    .ahb_req_o, .ahb_ack_i, .ahb_err_i, .rd_done_o, .rd_words_o,
    .pf_err_o);
`default_nettype wire
